/* File: pkg/abs_enc_consts.svh */
// Constants of the absolute encoder readout: timing, framing and character codes.
// Assumes a 10 MHz system clock; every cycle count below is derived from it.
`ifndef ABS_ENC_CONSTS_SVH
`define ABS_ENC_CONSTS_SVH

`define CLK_HZ 10000000
`define SEN_WAIT_MS 100
`define SETTLE_MS 50
`define SEN_WAIT_CYC ((`SEN_WAIT_MS * `CLK_HZ) / 1000)
`define SETTLE_CYC ((`SETTLE_MS * `CLK_HZ) / 1000)
`define BAUD_BPS 9600
`define BIT_CYC (`CLK_HZ / `BAUD_BPS)
`define CHAR_COUNT 8
`define LAST_CHAR 3'h7
`define FIRST_DIGIT 3'h2
`define PULSE_SHIFT 12
`define CH_P 7'h50
`define CH_A 7'h41
`define CH_PLUS 7'h2b
`define CH_MINUS 7'h2d
`define CH_ZERO 7'h30
`define CH_NINE 7'h39
`define CH_CR 7'h0d

`endif

/* File: pkg/abs_enc_pkg.sv */
// Types shared by the absolute encoder readout modules.
// Constants live in the companion header.
package abs_enc_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_wait,
        st_rx,
        st_settle,
        st_run,
        st_fault
    } readout_state_t;

    typedef enum logic [1:0] {
        rx_idle,
        rx_start,
        rx_bits,
        rx_stop
    } rx_state_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [6:0] data;
    } rx_char_t;

endpackage : abs_enc_pkg

/* File: rtl/absolute_encoder_readout.sv */
// Start-up readout of an absolute encoder: serial revolution count, initial pulses, then tracking.
// Assumes run_cmd and setup_capture come from logic on ref_clk; phase pins are asynchronous.
`timescale 1ns/1ns
`include "abs_enc_consts.svh"

module absolute_encoder_readout import abs_enc_pkg::*; #(
    parameter int SEN_WAIT_CYC = `SEN_WAIT_CYC,
    parameter int SETTLE_CYC = `SETTLE_CYC,
    parameter int BIT_CYC = `BIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Controller side
    input wire logic run_cmd,
    input wire logic setup_capture,
    // Encoder pins
    input wire logic phase_a,
    input wire logic phase_b,
    output logic sensor_on_request,
    // Results
    output logic signed [31:0] encoder_position,
    output logic signed [31:0] system_position,
    output logic signed [31:0] initial_pulse_count,
    output logic signed [31:0] setup_pulse_offset,
    output logic position_valid,
    output logic incremental_mode,
    output logic abs_error
);

    // Returns +1, -1 or 0 for one step of the quadrature pair.
    function automatic logic signed [31:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [3:0] t;
        t = {prev, cur};
        unique case (t)
            4'h1, 4'h7, 4'he, 4'h8: quad_step = 32'sh1;
            4'h2, 4'hb, 4'hd, 4'h4: quad_step = -32'sh1;
            default: quad_step = 32'sh0;
        endcase
    endfunction : quad_step

    function automatic logic is_digit(input logic [6:0] c);
        is_digit = (c >= `CH_ZERO) && (c <= `CH_NINE);
    endfunction : is_digit

    logic [1:0] meta_q, sync_q, prev_q;
    logic run_prev_q;
    rx_char_t rx_char;

    readout_state_t state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic [2:0] idx_q, idx_d;
    logic neg_q, neg_d;
    logic [16:0] rev_q, rev_d;
    logic sen_q, sen_d;
    logic err_q, err_d;
    logic valid_q, valid_d;
    logic inc_q, inc_d;
    logic signed [31:0] pulse_q, pulse_d;
    logic signed [31:0] enc_q, enc_d;
    logic signed [31:0] sys_q, sys_d;
    logic signed [31:0] off_q, off_d;
    logic signed [31:0] rev_s;
    logic signed [31:0] step;

    // Only phase A feeds the receiver; the encoder sends its serial frame on that pin.
    serial_char_rx #(
        .BIT_CYC(BIT_CYC)
    ) u_rx (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .enable(state_q == st_rx),
        .line(sync_q[1]),
        .char_out(rx_char)
    );

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta_q <= 2'h3;
            sync_q <= 2'h3;
            prev_q <= 2'h3;
            run_prev_q <= 1'b0;
        end else begin
            meta_q <= {phase_a, phase_b};
            sync_q <= meta_q;
            prev_q <= sync_q;
            run_prev_q <= run_cmd;
        end
    end

    always_comb begin
        rev_s = {15'h0000, rev_q};
        if (neg_q) begin
            rev_s = -rev_s;
        end
        step = quad_step(prev_q, sync_q);
        state_d = state_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        neg_d = neg_q;
        rev_d = rev_q;
        sen_d = sen_q;
        err_d = err_q;
        valid_d = valid_q;
        inc_d = 1'b0;
        pulse_d = pulse_q;
        enc_d = enc_q;
        off_d = setup_capture ? pulse_q : off_q;
        unique case (state_q)
            st_idle: begin
                if (run_cmd && !run_prev_q) begin
                    state_d = st_wait;
                    sen_d = 1'b1;
                    cnt_d = 32'h0;
                    err_d = 1'b0;
                    valid_d = 1'b0;
                end
            end
            st_wait: begin
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'(SEN_WAIT_CYC - 1)) begin
                    state_d = st_rx;
                    idx_d = 3'h0;
                    rev_d = 17'h0;
                    neg_d = 1'b0;
                end
            end
            st_rx: begin
                if (rx_char.valid) begin
                    idx_d = idx_q + 3'h1;
                    if (rx_char.fault) begin
                        state_d = st_fault;
                    end else if (idx_q == 3'h0) begin
                        if (rx_char.data != `CH_P && rx_char.data != `CH_A) begin
                            state_d = st_fault;
                        end
                    end else if (idx_q == 3'h1) begin
                        if (rx_char.data == `CH_MINUS) begin
                            neg_d = 1'b1;
                        end else if (rx_char.data != `CH_PLUS) begin
                            state_d = st_fault;
                        end
                    end else if (idx_q == `LAST_CHAR) begin
                        if (rx_char.data == `CH_CR) begin
                            state_d = st_settle;
                            cnt_d = 32'h0;
                            pulse_d = 32'sh0;
                        end else begin
                            state_d = st_fault;
                        end
                    end else if (is_digit(rx_char.data)) begin
                        rev_d = 17'(rev_q * 17'h0000a + 17'(rx_char.data - `CH_ZERO));
                    end else begin
                        state_d = st_fault;
                    end
                end
            end
            st_settle: begin
                // Initial pulses are gathered over the whole settle window.
                pulse_d = pulse_q + step;
                cnt_d = cnt_q + 32'h1;
                if (cnt_q == 32'(SETTLE_CYC - 1)) begin
                    state_d = st_run;
                    enc_d = (rev_s <<< `PULSE_SHIFT) + pulse_d;
                    valid_d = 1'b1;
                end
            end
            st_run: begin
                inc_d = 1'b1;
                enc_d = enc_q + step;
            end
            st_fault: begin
                err_d = 1'b1;
            end
        endcase
        // A revolution count past the valid range cannot occur: five digits always fit in rev_q, so it is not flagged here.
        if (!run_cmd) begin
            state_d = st_idle;
            sen_d = 1'b0;
            inc_d = 1'b0;
        end
        sys_d = enc_d - off_d;
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= st_idle;
            cnt_q <= 32'h0;
            idx_q <= 3'h0;
            neg_q <= 1'b0;
            rev_q <= 17'h0;
            sen_q <= 1'b0;
            err_q <= 1'b0;
            valid_q <= 1'b0;
            inc_q <= 1'b0;
            pulse_q <= 32'sh0;
            enc_q <= 32'sh0;
            sys_q <= 32'sh0;
            off_q <= 32'sh0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            neg_q <= neg_d;
            rev_q <= rev_d;
            sen_q <= sen_d;
            err_q <= err_d;
            valid_q <= valid_d;
            inc_q <= inc_d;
            pulse_q <= pulse_d;
            enc_q <= enc_d;
            sys_q <= sys_d;
            off_q <= off_d;
        end
    end

    assign sensor_on_request = sen_q;
    assign encoder_position = enc_q;
    assign system_position = sys_q;
    assign initial_pulse_count = pulse_q;
    assign setup_pulse_offset = off_q;
    assign position_valid = valid_q;
    assign incremental_mode = inc_q;
    assign abs_error = err_q;

    sequence s_run_rise;
        state_q == st_idle && run_cmd && !run_prev_q;
    endsequence

    chk_sen_rise: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_run_rise |=> sen_q && state_q == st_wait && cnt_q == 32'h0)
        else $error("Request not raised after run command.");

    chk_wait_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_rx && $past(state_q) == st_wait |-> $past(cnt_q) == 32'(SEN_WAIT_CYC - 1))
        else $error("Serial wait entered at wrong time.");

    chk_eight_chars: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_settle && $past(state_q) == st_rx |-> $past(idx_q) == `LAST_CHAR && idx_q == 3'h0)
        else $error("Transfer closed before eighth character.");

    chk_settle_exit: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_settle && cnt_q == 32'(SETTLE_CYC - 1) && run_cmd
        |=> state_q == st_run ##1 inc_q == $past(run_cmd))
        else $error("Incremental mode not entered after settle time.");

    chk_pulse_dir: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_settle && run_cmd && $past(state_q) == st_settle
        |=> pulse_q == $past(pulse_q) + $past(step))
        else $error("Initial pulse count wrong.");

    chk_pos_formula: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_run && $past(state_q) == st_settle
        |-> enc_q == ($past(rev_s) <<< `PULSE_SHIFT) + pulse_q)
        else $error("Encoder position formula broken.");

    chk_system_pos: assert property (@(posedge ref_clk) disable iff (!rstn)
        $past(rstn) |-> sys_q == enc_q - off_q)
        else $error("System position does not track offset.");

    chk_error_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_fault |=> err_q && !valid_q && $stable(enc_q))
        else $error("Faulted transfer changed position.");

    chk_zero_sign: assert property (@(posedge ref_clk) disable iff (!rstn)
        state_q == st_run && $past(state_q) == st_settle && rev_q == 17'h0 |-> enc_q == pulse_q)
        else $error("Negative zero not decoded as zero.");

endmodule : absolute_encoder_readout

/* File: rtl/serial_char_rx.sv */
// Receiver for one asynchronous character: start bit, 7 data bits, even parity, stop bit.
// Assumes its line input is already synchronised to ref_clk.
`timescale 1ns/1ns
`include "abs_enc_consts.svh"

module serial_char_rx import abs_enc_pkg::*; #(
    parameter int BIT_CYC = `BIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Line
    input wire logic enable,
    input wire logic line,
    // Character out
    output rx_char_t char_out
);

    rx_state_t state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0] idx_q, idx_d;
    logic [7:0] shift_q, shift_d;
    rx_char_t char_q, char_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        shift_d = shift_q;
        char_d = '{valid: 1'b0, fault: 1'b0, data: char_q.data};
        if (cnt_q != 16'h0000) begin
            cnt_d = cnt_q - 16'h0001;
        end
        unique case (state_q)
            rx_idle: begin
                if (enable && !line) begin
                    state_d = rx_start;
                    cnt_d = 16'(BIT_CYC / 2);
                end
            end
            rx_start: begin
                // Rechecking at mid-bit rejects short glitches as false starts.
                if (cnt_q == 16'h0000) begin
                    state_d = line ? rx_idle : rx_bits;
                    cnt_d = 16'(BIT_CYC - 1);
                    idx_d = 4'h0;
                end
            end
            rx_bits: begin
                if (cnt_q == 16'h0000) begin
                    shift_d = {line, shift_q[7:1]};
                    cnt_d = 16'(BIT_CYC - 1);
                    idx_d = idx_q + 4'h1;
                    if (idx_q == 4'h7) begin
                        state_d = rx_stop;
                    end
                end
            end
            rx_stop: begin
                if (cnt_q == 16'h0000) begin
                    state_d = rx_idle;
                    char_d.valid = 1'b1;
                    char_d.data = shift_q[6:0];
                    char_d.fault = !line || (^shift_q);
                end
            end
        endcase
        if (!enable) begin
            state_d = rx_idle;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_q <= rx_idle;
            cnt_q <= 16'h0000;
            idx_q <= 4'h0;
            shift_q <= 8'h00;
            char_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            shift_q <= shift_d;
            char_q <= char_d;
        end
    end

    assign char_out = char_q;

    chk_rx_parity: assert property (@(posedge ref_clk) disable iff (!rstn)
        char_q.valid && !char_q.fault |-> !(^$past(shift_q)) && $past(line))
        else $error("Character accepted with bad parity or stop bit.");

endmodule : serial_char_rx

/* File: tb/encoder_model.sv */
// Behavioural absolute encoder: serial revolution frame on phase A, then quadrature on A and B.
// Assumes callers start each task just after a rising edge of ref_clk.
`timescale 1ns/1ns

module encoder_model #(
    parameter int BIT_CYC = 16,
    parameter int SEN_WAIT_CYC = 50,
    parameter int STEP_CYC = 4
) (
    // Clock and request
    input wire logic ref_clk,
    input wire logic sensor_on_request,
    // Encoder phases
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] quad_q;

    // The line idles high, as if pulled up, so a released line is never mistaken for a start bit.
    initial begin
        phase_a = 1'b1;
        phase_b = 1'b0;
        quad_q = 2'h3;
    end

    task automatic hold_cycles(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : hold_cycles

    task automatic send_char(input logic [6:0] c, input logic bad_par, input logic bad_stop);
        logic [9:0] frame;
        frame = {~bad_stop, (^c) ^ bad_par, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            phase_a <= frame[i];
            hold_cycles(BIT_CYC);
        end
        // A broken stop bit must still end at the mark level before the next start bit.
        if (bad_stop) begin
            phase_a <= 1'b1;
            hold_cycles(1);
        end
    endtask : send_char

    task automatic glitch(input int n);
        phase_a <= 1'b0;
        hold_cycles(n);
        phase_a <= 1'b1;
    endtask : glitch

    // Gray order 00, 01, 11, 10 counts up.
    task automatic quad_step(input int dir);
        quad_q = quad_q + ((dir > 0) ? 2'h1 : 2'h3);
        phase_a <= quad_q[1];
        phase_b <= quad_q[1] ^ quad_q[0];
        hold_cycles(STEP_CYC);
    endtask : quad_step

    task automatic send_frame(input logic [6:0] lt, input logic [6:0] sg, input int rev, input int pulses,
                              input int mode, output logic ok);
        int r;
        int n;
        ok = 1'b0;
        for (n = 0; n < 100 && sensor_on_request !== 1'b1; n++) hold_cycles(1);
        if (sensor_on_request !== 1'b1) return;
        ok = 1'b1;
        // Phase A rests at the mark level before the frame, whatever quadrature state the last run left.
        phase_a <= 1'b1;
        hold_cycles(SEN_WAIT_CYC + 4);
        r = rev % 100000;
        send_char(lt, mode == 1, mode == 2);
        send_char(sg, 1'b0, 1'b0);
        for (int k = 4; k >= 0; k--) begin
            send_char(7'h30 + 7'((r / (10 ** k)) % 10), 1'b0, 1'b0);
        end
        if (mode != 4) send_char(7'h0d, 1'b0, 1'b0);
        hold_cycles(2 * BIT_CYC);
        quad_q = phase_b ? 2'h2 : 2'h3;
        for (n = 0; n < (pulses < 0 ? -pulses : pulses); n++) quad_step(pulses);
    endtask : send_frame
endmodule : encoder_model

/* File: tb/tb_top.sv */
// Bench for the absolute encoder readout: drives run and setup, judges positions and flags.
// Assumes the encoder model and shortened wait, settle and bit counts.
`timescale 1ns/1ns

module tb_top import abs_enc_pkg::*;;
    localparam int SEN_W = 50;
    localparam int SETTLE = 200;
    localparam int BITC = 16;
    logic ref_clk, rstn, run_cmd, setup_capture, phase_a, phase_b;
    logic sensor_on_request, position_valid, incremental_mode, abs_error;
    logic signed [31:0] encoder_position, system_position, initial_pulse_count, setup_pulse_offset;
    int fails = 0;
    int checks = 0;
    logic signed [31:0] offs = 0;
    logic signed [31:0] last_pos = 0;
    logic signed [31:0] last_pls = 0;

    absolute_encoder_readout #(.SEN_WAIT_CYC(SEN_W), .SETTLE_CYC(SETTLE), .BIT_CYC(BITC)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .run_cmd(run_cmd), .setup_capture(setup_capture),
        .phase_a(phase_a), .phase_b(phase_b), .sensor_on_request(sensor_on_request),
        .encoder_position(encoder_position), .system_position(system_position),
        .initial_pulse_count(initial_pulse_count), .setup_pulse_offset(setup_pulse_offset),
        .position_valid(position_valid), .incremental_mode(incremental_mode), .abs_error(abs_error));

    encoder_model #(.BIT_CYC(BITC), .SEN_WAIT_CYC(SEN_W), .STEP_CYC(4)) enc (
        .ref_clk(ref_clk), .sensor_on_request(sensor_on_request), .phase_a(phase_a), .phase_b(phase_b));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic signed [31:0] seen, input logic signed [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check

    task automatic edges(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : edges

    // A readout that never finishes would hang the run, so the wait is bounded.
    task automatic wait_done(input int bound);
        int n;
        for (n = 0; n < bound && position_valid !== 1'b1 && abs_error !== 1'b1; n++) edges(1);
        if (position_valid !== 1'b1 && abs_error !== 1'b1) begin
            fails++;
            report_and_stop();
        end
    endtask : wait_done

    task automatic readout(input logic [6:0] lt, input logic [6:0] sg, input int rev, input int pulses,
                           input int mode, input logic early);
        logic ok;
        logic signed [31:0] exp;
        exp = (sg == 7'h2d ? -rev : rev) * 4096 + pulses;
        @(posedge ref_clk);
        run_cmd <= 1'b0;
        repeat (3) @(posedge ref_clk);
        run_cmd <= 1'b1;
        edges(3);
        check("request", {31'h0, sensor_on_request}, 1);
        if (early) begin
            @(posedge ref_clk);
            enc.glitch(20);
        end
        @(posedge ref_clk);
        enc.send_frame(lt, sg, rev, pulses, mode, ok);
        check("frame sent", {31'h0, ok}, 1);
        edges(1);
        check("valid early", {31'h0, position_valid}, 0);
        if (mode == 4) begin
            edges(SETTLE * 2);
            check("short frame", {31'h0, position_valid | abs_error}, 0);
            return;
        end
        wait_done(SETTLE);
        check("error flag", {31'h0, abs_error}, mode != 0 ? 1 : 0);
        if (mode != 0) begin
            check("held position", encoder_position, last_pos);
            return;
        end
        check("pulses", initial_pulse_count, pulses);
        check("position", encoder_position, exp);
        check("system", system_position, exp - offs);
        edges(3);
        check("incremental", {31'h0, incremental_mode}, 1);
        last_pos = exp;
        last_pls = pulses;
    endtask : readout

    task automatic track();
        @(posedge ref_clk);
        repeat (3) enc.quad_step(1);
        enc.quad_step(-1);
        edges(6);
        last_pos = last_pos + 2;
        check("tracked", encoder_position, last_pos);
        check("tracked system", system_position, last_pos - offs);
    endtask : track

    task automatic capture();
        @(posedge ref_clk);
        setup_capture <= 1'b1;
        @(posedge ref_clk);
        setup_capture <= 1'b0;
        edges(4);
        offs = last_pls;
        check("offset", setup_pulse_offset, offs);
        check("system after setup", system_position, last_pos - offs);
    endtask : capture

    task automatic abort();
        @(posedge ref_clk);
        run_cmd <= 1'b0;
        edges(3);
        check("request off", {31'h0, sensor_on_request}, 0);
        check("incremental off", {31'h0, incremental_mode}, 0);
    endtask : abort

    initial begin
        rstn = 1'b0;
        run_cmd = 1'b0;
        setup_capture = 1'b0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        edges(3);
        check("reset request", {31'h0, sensor_on_request}, 0);
        readout(7'h50, 7'h2b, 12, -7, 0, 0);
        track();
        readout(7'h41, 7'h2d, 0, 5, 0, 0);
        readout(7'h50, 7'h2b, 0, -3, 0, 0);
        capture();
        readout(7'h50, 7'h2d, 345, -20, 0, 1);
        track();
        readout(7'h50, 7'h2b, 1, 0, 1, 0);
        readout(7'h50, 7'h2b, 1, 0, 2, 0);
        readout(7'h51, 7'h2b, 1, 0, 3, 0);
        readout(7'h50, 7'h2a, 1, 0, 3, 0);
        readout(7'h50, 7'h2b, 1, 0, 4, 0);
        readout(7'h41, 7'h2b, 99999, 30, 0, 0);
        abort();
        report_and_stop();
    end
endmodule : tb_top
